// ### rtl/rscl_map.vh
// Purpose: Register offsets, field positions, reset values and timing counts
// Assumes: APB with 32-bit data, one aligned word per register
// Notes:   Strap register offsets are locally chosen
`ifndef RSCL_MAP_VH
`define RSCL_MAP_VH

// ============================================================
// Register byte offsets
`define RSCL_OFF_PRIMARY      8'h00
`define RSCL_OFF_SECONDARY    8'h04
`define RSCL_OFF_RAW_PINS     8'h08

// ============================================================
// Primary strap register fields
`define RSCL_P_HOST_BUS       0
`define RSCL_P_FAST_LB        2
`define RSCL_P_EXT_CLK        3
`define RSCL_P_HW_SLEEP       4
`define RSCL_P_SLEEP_PORT     5
`define RSCL_P_LONG_BURST     7

// ============================================================
// Secondary strap register fields
`define RSCL_S_RELATCH        3
`define RSCL_S_FEATURE        7
`define RSCL_S_SW_MASK        8'h7F

// ============================================================
// Strap pin positions, relative to memory data bit 16
`define RSCL_PIN_HOST_BUS     0
`define RSCL_PIN_EXT_CLK      3
`define RSCL_PIN_HW_SLEEP     4
`define RSCL_PIN_SLEEP_PORT   5
`define RSCL_PIN_FEATURE      9
`define RSCL_PIN_UNSUP_MASK   10'h1C6

// ============================================================
// Reset values and decoded constants
`define RSCL_RST_PRIMARY      8'h00
`define RSCL_RST_SECONDARY    8'h00
`define RSCL_WAKE_PORT_LOCAL  16'h03C3
`define RSCL_WAKE_PORT_ALT    16'h46E8
`define RSCL_PCI_BURST_MIN    5'h08
`define RSCL_BURST_DEFAULT    5'h00

`endif

// ### rtl/rscl_edge_det.v
// Purpose: Rising and falling edge detector for a synchronous level
// Assumes: Input is already synchronous to CLK
// Notes:   History register resets to the given level
`timescale 1ns/100ps

module rscl_edge_det #(
  parameter INIT = 1'b0
) (
  // Clock and reset
  input  wire CLK,
  input  wire RST,
  // Level in, pulses out
  input  wire level_in,
  output wire rise,
  output wire fall
);

  reg prev_r;

  // ============================================================
  // History
  always @(posedge CLK) begin
    if (RST) begin
      prev_r <= INIT;
    end else begin
      prev_r <= level_in;
    end
  end

  assign rise = level_in & ~prev_r;
  assign fall = ~level_in & prev_r;

endmodule // rscl_edge_det

// ### rtl/rscl_apb_slave.v
// Purpose: Minimal APB slave front end, zero wait states
// Assumes: APB3 signalling, 32-bit data
// Notes:   Produces one-cycle write and read strobes in the access phase
`timescale 1ns/100ps

module rscl_apb_slave #(
  parameter AW = 8
) (
  // APB
  input  wire          psel,
  input  wire          penable,
  input  wire          pwrite,
  input  wire [AW-1:0] paddr,
  output wire          pready,
  // Strobes
  output wire          wr_stb,
  output wire          rd_stb,
  output wire [AW-1:0] reg_addr
);

  // ============================================================
  // Access phase decode
  assign pready   = 1'b1;
  assign wr_stb   = psel & penable & pwrite;
  assign rd_stb   = psel & penable & ~pwrite;
  assign reg_addr = paddr;

endmodule // rscl_apb_slave

// ### rtl/rscl_strap_latch.v
// Purpose: Latches board straps on memory data pins into two config registers
// Assumes: Pins sampled synchronously; pins carry internal pull-downs
// Notes:   Capture on system reset rising edge or on software relatch falling edge
`timescale 1ns/100ps
`include "rscl_map.vh"

// Notes on behaviour
// (R1) Sample the ten strap pins when system reset rises into config registers.
// (R2) Internal pull-down: unpulled pin reads 0, pulled-up pin reads 1.
// (R3) Software relatch bit falling 1 to 0 re-samples straps into both registers.
// (R4) Pin 25 strap lands in secondary bit 7, enabling feature connector port.
// (R5) Pin 21 strap lands in primary bit 5, choosing wake port 3C3h or 46E8h.
// (R6) Pin 20 strap lands in primary bit 4, enabling hardware sleep.
// (R7) Pin 19 strap lands in primary bit 3, selecting external clocks, synths off.
// (R8) Pin 16 strap lands in primary bit 0, selecting local or PCI host bus.
// (R9) PCI host bus selected means burst cycle minimum of eight host clocks.
// (R10) Board leaves pins 17, 18, 22, 23, 24 without pull-ups.
// (R11) Fast local bus bit 2 and long burst bit 7 are not implemented.
// (R12) Latched values hold between capture events.
module rscl_strap_latch #(
  parameter AW = 8
) (
  // Clock and reset
  input  wire          CLK,
  input  wire          RST,
  // System reset level, low while asserted; capture on its release
  input  wire          SYS_RESET,
  // Strap pins, memory data 25..16
  input  wire [9:0]    MEMORY_DATA_STRAP_PINS,
  output wire [9:0]    STRAP_PULLDOWN_OE,
  // APB
  input  wire          PSEL,
  input  wire          PENABLE,
  input  wire          PWRITE,
  input  wire [AW-1:0] PADDR,
  input  wire [31:0]   PWDATA,
  output reg  [31:0]   PRDATA,
  output wire          PREADY,
  output wire          PSLVERR,
  // Decoded configuration
  output wire          HOST_BUS_SELECT_STRAP,
  output wire          EXTERNAL_CLOCK_STRAP,
  output wire          HW_SLEEP_STRAP,
  output wire          SLEEP_PORT_SELECT_STRAP,
  output wire          FEATURE_PORT_STRAP,
  output wire          SYNTH_POWER_DOWN,
  output reg  [15:0]   WAKE_PORT_ADDR,
  output reg  [4:0]    PCI_BURST_MIN
);

  // ============================================================
  // Declarations
  reg  [7:0]    primary_r;
  reg  [7:0]    secondary_r;
  reg  [7:0]    primary_nxt;
  reg  [7:0]    secondary_nxt;
  reg  [9:0]    pins_r;
  wire          wr_stb;
  wire          rd_stb;
  wire [AW-1:0] reg_addr;
  wire          rst_rise;
  wire          relatch_fall;
  wire          relatch_lvl;
  wire          capture;
  wire          sec_wr;

  // ============================================================
  // Helpers
  function [7:0] map_primary;
    input [9:0] p;
    begin
      map_primary = 8'h00;
      map_primary[`RSCL_P_HOST_BUS]   = p[`RSCL_PIN_HOST_BUS];   // [R8]
      map_primary[`RSCL_P_EXT_CLK]    = p[`RSCL_PIN_EXT_CLK];    // [R7]
      map_primary[`RSCL_P_HW_SLEEP]   = p[`RSCL_PIN_HW_SLEEP];   // [R6]
      map_primary[`RSCL_P_SLEEP_PORT] = p[`RSCL_PIN_SLEEP_PORT]; // [R5]
      // Bits 2 and 7 stay zero: options dropped [R11]
    end
  endfunction

  // ============================================================
  // Bus front end
  rscl_apb_slave #(.AW(AW)) u_apb (
    .psel     (PSEL),
    .penable  (PENABLE),
    .pwrite   (PWRITE),
    .paddr    (PADDR),
    .pready   (PREADY),
    .wr_stb   (wr_stb),
    .rd_stb   (rd_stb),
    .reg_addr (reg_addr)
  );

  assign PSLVERR = 1'b0;

  // ============================================================
  // Pull-downs always on; board pull-ups win [R2]
  assign STRAP_PULLDOWN_OE = 10'h3FF;

  // ============================================================
  // Capture events
  // Rising edge of the system reset level, seen on our clock [R1]
  rscl_edge_det #(.INIT(1'b0)) u_sysrst (
    .CLK      (CLK),
    .RST      (RST),
    .level_in (SYS_RESET),
    .rise     (rst_rise),
    .fall     ()
  );

  assign relatch_lvl = secondary_r[`RSCL_S_RELATCH];

  rscl_edge_det #(.INIT(1'b0)) u_relatch (
    .CLK      (CLK),
    .RST      (RST),
    .level_in (relatch_lvl),
    .rise     (),
    .fall     (relatch_fall)
  );

  assign capture = rst_rise | relatch_fall; // [R1] [R3] [R12]
  assign sec_wr  = wr_stb & (reg_addr == `RSCL_OFF_SECONDARY);

  // ============================================================
  // Register next state
  always @* begin
    primary_nxt   = primary_r;
    secondary_nxt = secondary_r;
    // Software writes only the low bits; strap bit 7 is hardware owned
    if (sec_wr) begin
      secondary_nxt = (secondary_r & ~`RSCL_S_SW_MASK) | (PWDATA[7:0] & `RSCL_S_SW_MASK);
    end
    // Capture wins over the software write on strap bits [R12]
    if (capture) begin
      primary_nxt = map_primary(pins_r);
      secondary_nxt[`RSCL_S_FEATURE] = pins_r[`RSCL_PIN_FEATURE]; // [R4]
    end
  end

  always @(posedge CLK) begin
    if (RST) begin
      primary_r   <= `RSCL_RST_PRIMARY;
      secondary_r <= `RSCL_RST_SECONDARY;
    end else begin
      primary_r   <= primary_nxt;
      secondary_r <= secondary_nxt;
    end
  end

  // Sampled through reset too, so a capture at reset exit sees real levels
  always @(posedge CLK) begin
    pins_r <= MEMORY_DATA_STRAP_PINS; // [R1] [R3]
  end

  // ============================================================
  // Read path
  always @* begin
    PRDATA = 32'h00000000;
    if (rd_stb) begin
      case (reg_addr)
        `RSCL_OFF_PRIMARY:   PRDATA = {24'h000000, primary_r};
        `RSCL_OFF_SECONDARY: PRDATA = {24'h000000, secondary_r};
        `RSCL_OFF_RAW_PINS:  PRDATA = {22'h0, pins_r};
        default:             PRDATA = 32'h00000000;
      endcase
    end
  end

  // ============================================================
  // Decoded configuration outputs
  assign HOST_BUS_SELECT_STRAP   = primary_r[`RSCL_P_HOST_BUS];   // [R8]
  assign EXTERNAL_CLOCK_STRAP    = primary_r[`RSCL_P_EXT_CLK];    // [R7]
  assign SYNTH_POWER_DOWN        = primary_r[`RSCL_P_EXT_CLK];    // [R7]
  assign HW_SLEEP_STRAP          = primary_r[`RSCL_P_HW_SLEEP];   // [R6]
  assign SLEEP_PORT_SELECT_STRAP = primary_r[`RSCL_P_SLEEP_PORT]; // [R5]
  assign FEATURE_PORT_STRAP      = secondary_r[`RSCL_S_FEATURE];  // [R4]

  always @* begin
    if (primary_r[`RSCL_P_SLEEP_PORT]) begin
      WAKE_PORT_ADDR = `RSCL_WAKE_PORT_ALT;   // [R5]
    end else begin
      WAKE_PORT_ADDR = `RSCL_WAKE_PORT_LOCAL; // [R5]
    end
    if (primary_r[`RSCL_P_HOST_BUS]) begin
      PCI_BURST_MIN = `RSCL_PCI_BURST_MIN;    // [R9]
    end else begin
      PCI_BURST_MIN = `RSCL_BURST_DEFAULT;
    end
  end

endmodule // rscl_strap_latch

// ### verif/rscl_pullups.sv
// Purpose: Board pull-up resistors on the strap pins
// Assumes: Pull-downs sit inside the device
// Notes:   An open pin with its pull-down off reads 1, never a stale level
`timescale 1ns/100ps
// ========
// Pull-up model
module rscl_pullups (
  // Fitted pull-ups and device pull-down enables
  input  wire logic [9:0] mask,
  input  wire logic [9:0] pd_oe,
  // Pin levels
  output wire logic [9:0] pins
);
  assign pins = mask | ~pd_oe;
endmodule // rscl_pullups

// ### verif/rscl_latch_sva.sv
// Purpose: Port assertions for the strap latch
// Assumes: Zero-wait APB, two-edge capture latency
// Notes:   Bound into every strap latch instance
`timescale 1ns/100ps
// ========
// Checker
module rscl_latch_sva (
  // Clock, reset, capture cause
  input logic        CLK,
  input logic        RST,
  input logic        SYS_RESET,
  input logic [9:0]  MEMORY_DATA_STRAP_PINS,
  // APB
  input logic        PSEL,
  input logic        PENABLE,
  input logic        PWRITE,
  input logic [7:0]  PADDR,
  input logic [31:0] PRDATA,
  // Configuration
  input logic        HOST_BUS_SELECT_STRAP,
  input logic        EXTERNAL_CLOCK_STRAP,
  input logic        HW_SLEEP_STRAP,
  input logic        SLEEP_PORT_SELECT_STRAP,
  input logic        FEATURE_PORT_STRAP,
  input logic        SYNTH_POWER_DOWN,
  input logic [15:0] WAKE_PORT_ADDR,
  input logic [4:0]  PCI_BURST_MIN
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  wire [5:0] cfg = {FEATURE_PORT_STRAP, SLEEP_PORT_SELECT_STRAP, HW_SLEEP_STRAP,
                    EXTERNAL_CLOCK_STRAP, SYNTH_POWER_DOWN, HOST_BUS_SELECT_STRAP};
  wire       wr_sec = PSEL && PENABLE && PWRITE && PADDR == 8'h04;
  // Release seen inside reset is not a capture
  sequence rel;
    $rose(SYS_RESET) && !$past(RST);
  endsequence
  a_cap_host: assert property (
    rel |=> HOST_BUS_SELECT_STRAP == $past(MEMORY_DATA_STRAP_PINS[0], 2))
    else $error("host bus strap not captured");
  a_cap_feature: assert property (
    rel |=> FEATURE_PORT_STRAP == $past(MEMORY_DATA_STRAP_PINS[9], 2))
    else $error("feature strap not captured");
  a_cap_port: assert property (
    rel |=> SLEEP_PORT_SELECT_STRAP == $past(MEMORY_DATA_STRAP_PINS[5], 2))
    else $error("sleep port strap not captured");
  a_cap_sleep: assert property (
    rel |=> HW_SLEEP_STRAP == $past(MEMORY_DATA_STRAP_PINS[4], 2))
    else $error("sleep strap not captured");
  a_cap_clock: assert property (
    rel |=> EXTERNAL_CLOCK_STRAP == $past(MEMORY_DATA_STRAP_PINS[3], 2))
    else $error("clock strap not captured");
  a_wake_port: assert property (
    WAKE_PORT_ADDR == (SLEEP_PORT_SELECT_STRAP ? 16'h46E8 : 16'h03C3))
    else $error("wake port wrong");
  a_burst_min: assert property (
    PCI_BURST_MIN == (HOST_BUS_SELECT_STRAP ? 5'h08 : 5'h00))
    else $error("burst minimum wrong");
  a_synth_off: assert property (
    SYNTH_POWER_DOWN == EXTERNAL_CLOCK_STRAP) else $error("synth power wrong");
  a_hold_steady: assert property (
    $changed(cfg) |-> ($past(SYS_RESET) && !$past(SYS_RESET, 2)) ||
                      $past(wr_sec, 2) || $past(wr_sec, 3))
    else $error("strap changed without capture");
  a_unsup_zero: assert property (
    PSEL && PENABLE && !PWRITE && PADDR == 8'h00 |-> PRDATA[7] == 0 && PRDATA[2] == 0)
    else $error("unsupported bit set");
endmodule // rscl_latch_sva
bind rscl_strap_latch rscl_latch_sva sva_u (.CLK, .RST, .SYS_RESET,
  .MEMORY_DATA_STRAP_PINS, .PSEL, .PENABLE, .PWRITE, .PADDR, .PRDATA,
  .HOST_BUS_SELECT_STRAP, .EXTERNAL_CLOCK_STRAP, .HW_SLEEP_STRAP,
  .SLEEP_PORT_SELECT_STRAP, .FEATURE_PORT_STRAP, .SYNTH_POWER_DOWN,
  .WAKE_PORT_ADDR, .PCI_BURST_MIN);

// ### verif/tb.sv
// Purpose: Self-checking bench for the strap latch
// Assumes: Zero-wait APB, pins held steady around each capture
// Notes:   Masks never fit pull-ups on unsupported pins
`timescale 1ns/100ps
`include "rscl_map.vh"
// ========
// Bench
module tb;
  logic        clk = 0, rst = 1, sys_reset = 1, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, rd;
  logic [9:0]  mask = 10'h000;
  wire  [9:0]  pins, oe;
  wire  [31:0] prdata;
  wire         pready, slverr, host, ext, sleep, port, feat, synth;
  wire  [15:0] wake;
  wire  [4:0]  burst;
  int          n_errors = 0, comparisons = 0, cyc = 0;
  always #2 clk = ~clk;
  rscl_pullups pu_u (.mask(mask), .pd_oe(oe), .pins(pins));
  rscl_strap_latch dut_u (.CLK(clk), .RST(rst), .SYS_RESET(sys_reset),
    .MEMORY_DATA_STRAP_PINS(pins), .STRAP_PULLDOWN_OE(oe), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(slverr), .HOST_BUS_SELECT_STRAP(host),
    .EXTERNAL_CLOCK_STRAP(ext), .HW_SLEEP_STRAP(sleep), .SLEEP_PORT_SELECT_STRAP(port),
    .FEATURE_PORT_STRAP(feat), .SYNTH_POWER_DOWN(synth), .WAKE_PORT_ADDR(wake),
    .PCI_BURST_MIN(burst));
  task check(input string nm, input logic [31:0] got, exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk) penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    psel <= 0;
    penable <= 0;
  endtask
  // Leaves the secondary word in rd
  task chk_cfg(input logic [9:0] m);
    apb(0, `RSCL_OFF_PRIMARY, 0);
    check("primary", rd, {24'h0, 2'b00, m[5:3], 2'b00, m[0]});
    apb(0, `RSCL_OFF_SECONDARY, 0);
    check("secondary bit 7", rd[7], m[9]);
    check("outputs", {feat, port, sleep, ext, synth, host},
          {m[9], m[5:3], m[3], m[0]});
    check("wake port", wake, m[5] ? 16'h46E8 : 16'h03C3);
    check("burst", burst, m[0] ? 5'h08 : 5'h00);
  endtask
  task t_reset;
    chk_cfg(10'h000);
    check("secondary", rd, 0);
  endtask
  task t_sysrst;
    logic [9:0] m [3] = '{10'h239, 10'h011, 10'h000};
    foreach (m[i]) begin
      mask <= m[i];
      sys_reset <= 0;
      repeat (3) @(posedge clk);
      sys_reset <= 1;
      repeat (4) @(posedge clk);
      chk_cfg(m[i]);
    end
  endtask
  task t_relatch;
    mask <= 10'h238;
    repeat (4) @(posedge clk);
    chk_cfg(10'h000);
    apb(1, `RSCL_OFF_SECONDARY, 32'h08);
    apb(1, `RSCL_OFF_SECONDARY, 32'h00);
    repeat (4) @(posedge clk);
    chk_cfg(10'h238);
  endtask
  // Read-only places refuse writes
  task t_access;
    apb(1, `RSCL_OFF_PRIMARY, 32'hFF);
    apb(1, `RSCL_OFF_SECONDARY, 32'h77);
    chk_cfg(10'h238);
    check("secondary", rd, 32'hF7);
    apb(0, `RSCL_OFF_RAW_PINS, 0);
    check("raw pins", rd, 32'h238);
    apb(0, 8'h0C, 0);
    check("unmapped", rd, 0);
    check("slverr", slverr, 0);
  endtask
  task close_out;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rst <= 0;
    t_reset;
    t_sysrst;
    t_relatch;
    t_access;
    close_out;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      n_errors++;
      close_out;
    end
  end
endmodule // tb
